// ===== logic/loopback_regs.v
// Loopback control, receive error counter and power-down registers.
// Assumes an AXI4-Lite master, error events as one-cycle pulses and
// a link-up level from the PHY core, all on clk_i.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "loopback_regs_consts.vh"

module loopback_regs #(
  parameter SETTLE_CYCLES = `MII_SETTLE_US * `CLK_MHZ
) (
  input wire clk_i,
  input wire rst_i,
  // AXI4-Lite slave
  input wire [6:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [6:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // PHY core side
  input wire link_up_i,
  input wire crc_err_i,
  input wire symbol_err_i,
  input wire false_carrier_i,
  output reg mii_loopback_o,
  output reg all_digital_loopback_o,
  output reg line_driver_loopback_o,
  output reg remote_loopback_o,
  output reg ext_cable_loopback_o,
  output reg tx_suppress_o,
  output reg link_status_o,
  output reg ready_for_data_o,
  output reg edpd_enable_o,
  output reg idle_link_pulse_o,
  output wire irq_o
);

  // ************************************************************
  // Registers
  // ************************************************************
  reg [15:0] loopback_r;
  reg [15:0] pwrdn_r;
  reg [15:0] errsel_r;
  reg [15:0] errcnt_r;
  reg [15:0] errcnt_nxt;
  reg [1:0] irq_status_r;
  reg [1:0] irq_mask_r;
  reg [1:0] irq_set;
  reg [31:0] settle_r;
  reg link_status_d_r;
  // Blocks a false link-change event on the first edge after reset
  reg link_seen_r;

  reg aw_held_r;
  reg w_held_r;
  reg [4:0] aw_idx_r;
  reg [15:0] wdata_r;
  reg [1:0] wstrb_r;

  // ************************************************************
  // Write channel
  // ************************************************************
  // Address and data latched separately so either may come first
  assign s_axi_awready_o = !aw_held_r && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held_r && !s_axi_bvalid_o;

  wire do_write = aw_held_r && w_held_r && !s_axi_bvalid_o;
  wire aw_ok = aw_idx_r == `IDX_LOOPBACK || aw_idx_r == `IDX_ERRCNT ||
               aw_idx_r == `IDX_PWRDN || aw_idx_r == `IDX_ERRSEL ||
               aw_idx_r == `IDX_IRQ_STATUS || aw_idx_r == `IDX_IRQ_MASK;

  // Byte-lane merge of the low 16 bits
  function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0] strb;
    input [15:0] wmask;
    begin
      merge = old;
      if (strb[0]) begin
        merge[7:0] = (nw[7:0] & wmask[7:0]) | (old[7:0] & ~wmask[7:0]);
      end
      if (strb[1]) begin
        merge[15:8] = (nw[15:8] & wmask[15:8]) |
                      (old[15:8] & ~wmask[15:8]);
      end
    end
  endfunction

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_idx_r <= 5'h00;
      wdata_r <= 16'h0000;
      wstrb_r <= 2'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= 2'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr_i[6:2];
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata_i[15:0];
        wstrb_r <= s_axi_wstrb_i[1:0];
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= aw_ok ? 2'h0 : 2'h3;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Read channel
  // ************************************************************
  assign s_axi_arready_o = !s_axi_rvalid_o;
  wire do_read = s_axi_arvalid_i && s_axi_arready_o;
  wire [4:0] ar_idx = s_axi_araddr_i[6:2];
  wire cnt_read = do_read && ar_idx == `IDX_ERRCNT;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= 2'h0;
    end else if (do_read) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= 2'h0;
      case (ar_idx)
        // Reserved bits are never stored, so they read zero
        `IDX_LOOPBACK: s_axi_rdata_o <= {16'h0000, loopback_r};
        `IDX_ERRCNT: s_axi_rdata_o <= {16'h0000, errcnt_r};
        `IDX_PWRDN: s_axi_rdata_o <= {16'h0000, pwrdn_r};
        `IDX_ERRSEL: s_axi_rdata_o <= {16'h0000, errsel_r};
        `IDX_IRQ_STATUS: s_axi_rdata_o <= {30'h00000000, irq_status_r};
        `IDX_IRQ_MASK: s_axi_rdata_o <= {30'h00000000, irq_mask_r};
        default: begin
          s_axi_rdata_o <= 32'h00000000;
          s_axi_rresp_o <= 2'h3;
        end
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      loopback_r <= `LB_RESET;
      pwrdn_r <= `PD_RESET;
      errsel_r <= 16'h0000;
      irq_mask_r <= 2'h0;
    end else if (do_write) begin
      case (aw_idx_r)
        `IDX_LOOPBACK:
          loopback_r <= merge(loopback_r, wdata_r, wstrb_r, `LB_WMASK);
        `IDX_PWRDN:
          pwrdn_r <= merge(pwrdn_r, wdata_r, wstrb_r, `PD_WMASK);
        `IDX_ERRSEL:
          errsel_r <= merge(errsel_r, wdata_r, wstrb_r, `SEL_WMASK);
        `IDX_IRQ_MASK:
          if (wstrb_r[0]) begin
            irq_mask_r <= wdata_r[1:0] & `IRQ_WMASK;
          end
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // Receive error counter
  // ************************************************************
  // Saturates rather than wraps so a long burst is not hidden
  always @* begin
    errcnt_nxt = errcnt_r;
    if ((errsel_r[`SEL_SYMBOL] ? symbol_err_i : crc_err_i) ||
        (errsel_r[`SEL_FALSECAR] && false_carrier_i)) begin
      if (errcnt_r != 16'hffff) begin
        errcnt_nxt = errcnt_r + 16'h0001;
      end
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      errcnt_r <= 16'h0000;
    end else if (cnt_read) begin
      errcnt_r <= 16'h0000;
    end else begin
      errcnt_r <= errcnt_nxt;
    end
  end

  // ************************************************************
  // Loopback mode decode
  // ************************************************************
  wire mii_lb = loopback_r[`LB_MII];
  wire settled = settle_r >= SETTLE_CYCLES;
  wire link_now = mii_lb ? loopback_r[`LB_FORCELINK] : link_up_i;

  // Settle timer restarts on every entry into MII loopback
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      settle_r <= 32'h00000000;
    end else if (!mii_lb) begin
      settle_r <= 32'h00000000;
    end else if (!settled) begin
      settle_r <= settle_r + 32'h00000001;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mii_loopback_o <= 1'b0;
      all_digital_loopback_o <= 1'b0;
      line_driver_loopback_o <= 1'b0;
      remote_loopback_o <= 1'b0;
      ext_cable_loopback_o <= 1'b0;
      tx_suppress_o <= 1'b0;
      link_status_o <= 1'b0;
      ready_for_data_o <= 1'b0;
      edpd_enable_o <= 1'b0;
      idle_link_pulse_o <= 1'b0;
    end else begin
      mii_loopback_o <= mii_lb;
      all_digital_loopback_o <= loopback_r[`LB_ALLDIG];
      line_driver_loopback_o <= loopback_r[`LB_LINEDRV];
      remote_loopback_o <= loopback_r[`LB_REMOTE];
      ext_cable_loopback_o <= loopback_r[`LB_EXTCABLE];
      tx_suppress_o <= loopback_r[`LB_ALLDIG] &&
                       loopback_r[`LB_TXSUPP];
      // Forced in MII loopback, live link otherwise
      link_status_o <= link_now;
      if (loopback_r[`LB_REMOTE]) begin
        ready_for_data_o <= 1'b0;
      end else if (mii_lb) begin
        ready_for_data_o <= settled;
      end else begin
        ready_for_data_o <= link_now;
      end
      edpd_enable_o <= pwrdn_r[`PD_EDPD];
      idle_link_pulse_o <= pwrdn_r[`PD_EDPD] && pwrdn_r[`PD_PULSE];
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  always @* begin
    irq_set = 2'h0;
    irq_set[`IRQ_LINK_CHG] = link_seen_r && (link_now != link_status_d_r);
    irq_set[`IRQ_CNT_SAT] = errcnt_nxt == 16'hffff &&
                            errcnt_r != 16'hffff && !cnt_read;
  end

  // Set wins over a simultaneous write-one-to-clear
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status_r <= 2'h0;
      link_status_d_r <= 1'b0;
      link_seen_r <= 1'b0;
    end else begin
      link_status_d_r <= link_now;
      link_seen_r <= 1'b1;
      if (do_write && aw_idx_r == `IDX_IRQ_STATUS && wstrb_r[0]) begin
        irq_status_r <= (irq_status_r & ~wdata_r[1:0]) | irq_set;
      end else begin
        irq_status_r <= irq_status_r | irq_set;
      end
    end
  end

  assign irq_o = |(irq_status_r & irq_mask_r);

endmodule

// ===== logic/loopback_regs_consts.vh
// Constants for the loopback and diagnostic register bank.
// Assumes an AXI4-Lite master with 32-bit data on the far side.
`ifndef LOOPBACK_REGS_CONSTS_VH
`define LOOPBACK_REGS_CONSTS_VH

// Printed offsets are not multiples of four: kept as indices
`define IDX_LOOPBACK 5'h13
`define IDX_ERRCNT 5'h14
`define IDX_PWRDN 5'h15
`define IDX_ERRSEL 5'h18
`define IDX_IRQ_STATUS 5'h1c
`define IDX_IRQ_MASK 5'h1d

`define LB_MII 15
`define LB_ALLDIG 12
`define LB_LINEDRV 10
`define LB_REMOTE 9
`define LB_EXTCABLE 7
`define LB_TXSUPP 6
`define LB_FORCELINK 0
`define LB_WMASK 16'h96c1
`define LB_RESET 16'h1041

`define PD_EDPD 3
`define PD_PULSE 2
`define PD_WMASK 16'h000c
`define PD_RESET 16'h000c

`define SEL_SYMBOL 13
`define SEL_FALSECAR 14
`define SEL_WMASK 16'h6000

// Interrupt status bits
`define IRQ_LINK_CHG 0
`define IRQ_CNT_SAT 1
`define IRQ_WMASK 2'h3

// MII loopback settle time, two milliseconds
`define MII_SETTLE_US 2000
`define CLK_MHZ 125

`endif

// ===== verification/loopback_regs_chk.sv
// Assertions on the loopback register bank ports.
// Assumes one clock domain with an active-high async reset.
`timescale 1ns/100ps
module loopback_regs_chk (
  input wire clk_i,
  input wire rst_i,
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire link_up_i,
  input wire mii_loopback_o,
  input wire all_digital_loopback_o,
  input wire remote_loopback_o,
  input wire tx_suppress_o,
  input wire link_status_o,
  input wire ready_for_data_o,
  input wire edpd_enable_o,
  input wire idle_link_pulse_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence w_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence r_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  a_txsupp_alldig: assert property (tx_suppress_o |-> all_digital_loopback_o)
    else $error("transmit suppressed outside all-digital loopback");
  a_pulse_edpd: assert property (idle_link_pulse_o |-> edpd_enable_o)
    else $error("idle link pulses without power-down enable");
  a_remote_ready: assert property (remote_loopback_o |-> !ready_for_data_o)
    else $error("ready for data in remote loopback");
  a_link_follows: assert property (
    !mii_loopback_o |-> link_status_o == $past(link_up_i))
    else $error("link status not following the link");
  // Settle time is above 8 cycles in both builds: 20 in the bench, 250000 by default
  a_mii_settles: assert property (
    $rose(mii_loopback_o) |-> !ready_for_data_o [*8])
    else $error("ready too soon after entering MII loopback");
  a_write_answer: assert property (w_taken |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response missing");
  a_read_answer: assert property (r_taken |=> s_axi_rvalid_o)
    else $error("read answer missing");
  a_read_single: assert property (
    s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read answer repeated");
  a_upper_zero: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0)
    else $error("upper read data not zero");
endmodule
bind loopback_regs loopback_regs_chk chk (.*);

// ===== verification/mgmt_host.sv
// Management host: AXI4-Lite master, one transfer at a time.
// Assumes wr and rd are called just after a rising clk_i edge.
`timescale 1ns/100ps
module mgmt_host (
  input wire clk_i,
  output logic [6:0] s_axi_awaddr_i,
  output logic s_axi_awvalid_i,
  input wire s_axi_awready_o,
  output logic [31:0] s_axi_wdata_i,
  output logic [3:0] s_axi_wstrb_i,
  output logic s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire [1:0] s_axi_bresp_o,
  input wire s_axi_bvalid_o,
  output logic s_axi_bready_i,
  output logic [6:0] s_axi_araddr_i,
  output logic s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire [1:0] s_axi_rresp_o,
  input wire s_axi_rvalid_o,
  output logic s_axi_rready_i
);
  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
    {s_axi_arvalid_i, s_axi_rready_i} = 2'h0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 46'h0;
    s_axi_wstrb_i = 4'h3;
  end
  // Ready and answers are taken at the rising edge that completes them
  task wr(input [6:0] a, input [15:0] d, output [1:0] r);
    bit pa, pw, pb, ga, gw, gb;
    int n;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {16'h0, d};
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
    {pa, pw, pb} = 3'h7;
    r = 2'h2;
    for (n = 0; n < 64 && pb; n++) begin
      @(posedge clk_i);
      ga = pa & s_axi_awready_o;
      gw = pw & s_axi_wready_o;
      gb = s_axi_bvalid_o;
      if (gb) r = s_axi_bresp_o;
      if (ga) s_axi_awvalid_i <= 1'b0;
      if (gw) s_axi_wvalid_i <= 1'b0;
      if (gb) s_axi_bready_i <= 1'b0;
      {pa, pw, pb} = {pa & !ga, pw & !gw, pb & !gb};
    end
    if (pb) test_phy_loopback_diag_regs.stall();
  endtask
  task rd(input [6:0] a, output [31:0] d, output [1:0] r);
    bit pa, pb, ga, gb;
    int n;
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
    {pa, pb} = 2'h3;
    for (n = 0; n < 64 && pb; n++) begin
      @(posedge clk_i);
      {ga, gb} = {pa & s_axi_arready_o, s_axi_rvalid_o};
      if (gb) {d, r} = {s_axi_rdata_o, s_axi_rresp_o};
      if (ga) s_axi_arvalid_i <= 1'b0;
      if (gb) s_axi_rready_i <= 1'b0;
      {pa, pb} = {pa & !ga, pb & !gb};
    end
    if (pb) test_phy_loopback_diag_regs.stall();
  endtask
endmodule

// ===== verification/test_phy_loopback_diag_regs.sv
// Self-checking bench for the loopback register bank.
// Assumes mgmt_host drives the bus; error events are driven here.
`timescale 1ns/100ps
module test_phy_loopback_diag_regs;
  logic clk_i = 0, rst_i = 1, link_up_i = 0, crc_err_i = 0;
  logic symbol_err_i = 0, false_carrier_i = 0;
  logic [6:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, seed = 32'h6bd3, v, got;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic s_axi_rvalid_o, s_axi_rready_i, mii_loopback_o, irq_o;
  logic all_digital_loopback_o, line_driver_loopback_o, remote_loopback_o;
  logic ext_cable_loopback_o, tx_suppress_o, link_status_o;
  logic ready_for_data_o, edpd_enable_o, idle_link_pulse_o;
  // Host keeps the general loopback bit outside this block per mode
  logic [15:0] modes [6] = '{16'h8001, 16'h8000, 16'h1000, 16'h0400,
    16'h0080, 16'h0200};
  int mismatches = 0, samples_checked = 0, cnt, i, k;
  always #4 clk_i = ~clk_i;
  loopback_regs #(.SETTLE_CYCLES(20)) uut (.*);
  mgmt_host host (.*);
  task check(input [31:0] seen, input [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checked %0d, mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task stall;
    mismatches++;
    wrap_up();
  endtask
  task rdchk(input [6:0] a, input [31:0] exp);
    host.rd(a, got, resp);
    check(got, exp);
  endtask
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // One-cycle events: bit 0 CRC, bit 1 symbol, bit 2 false carrier
  task pulse(input [2:0] m);
    @(posedge clk_i);
    {false_carrier_i, symbol_err_i, crc_err_i} <= m;
    @(posedge clk_i);
    {false_carrier_i, symbol_err_i, crc_err_i} <= 3'h0;
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    check({all_digital_loopback_o, tx_suppress_o, edpd_enable_o,
      idle_link_pulse_o}, 4'hf);
    rdchk(7'h4c, 32'h1041);
    rdchk(7'h54, 32'h000c);
    rdchk(7'h50, 32'h0);
    $display("reset values done");
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      v = seed;
      host.wr(7'h4c, v[15:0], resp);
      host.wr(7'h54, v[31:16], resp);
      rdchk(7'h4c, v & 32'h96c1);
      rdchk(7'h54, v[31:16] & 32'h000c);
      @(negedge clk_i);
      check({mii_loopback_o, all_digital_loopback_o, line_driver_loopback_o,
        remote_loopback_o, ext_cable_loopback_o, tx_suppress_o},
        {v[15], v[12], v[10], v[9], v[7], v[12] & v[6]});
      check({edpd_enable_o, idle_link_pulse_o},
        {v[19], v[19] & v[18]});
    end
    $display("random writes done");
    host.wr(7'h4c, 16'h0000, resp);
    link_up_i <= 1'b1;
    for (k = 0; k < 6; k++) begin
      v = modes[k];
      host.wr(7'h4c, v[15:0], resp);
      @(negedge clk_i);
      if (k == 0) check(ready_for_data_o, 1'b0);
      repeat (24) @(negedge clk_i);
      check(link_status_o, v[15] ? v[0] : 1'b1);
      check(ready_for_data_o, !v[9]);
    end
    $display("loopback modes done");
    for (k = 0; k < 4; k++) begin
      host.wr(7'h60, 16'(k << 13), resp);
      rdchk(7'h60, k << 13);
      host.rd(7'h50, got, resp);
      cnt = 0;
      for (i = 1; i < 8; i++) begin
        pulse(3'(i));
        cnt += (k[0] ? i[1] : i[0]) | (k[1] & i[2]);
      end
      rdchk(7'h50, cnt);
      rdchk(7'h50, 32'h0);
    end
    $display("error counter done");
    host.wr(7'h70, 16'h0003, resp);
    host.wr(7'h74, 16'h0000, resp);
    link_up_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    check(irq_o, 1'b0);
    rdchk(7'h70, 32'h1);
    host.wr(7'h74, 16'h0001, resp);
    @(negedge clk_i);
    check(irq_o, 1'b1);
    host.wr(7'h70, 16'h0001, resp);
    @(negedge clk_i);
    check(irq_o, 1'b0);
    host.rd(7'h00, got, resp);
    check(got, 32'h0);
    check(resp, 2'h3);
    host.wr(7'h00, 16'hffff, resp);
    check(resp, 2'h3);
    $display("interrupt and unmapped done");
    wrap_up();
  end
endmodule
